// ==== hw/break_pkg.sv ====
// Shared types and constants for the address break unit
package break_pkg;

    localparam logic [15:0] VECTOR_NORMAL     = 16'hfffc;
    localparam logic [15:0] VECTOR_MONITOR    = 16'hfefc;
    // Opcode forced into the instruction register; value set by the core integration
    localparam logic [7:0]  SWI_OPCODE        = 8'h83;

    localparam int          CTRL_ENABLE_POS   = 7;
    localparam int          CTRL_REQUEST_POS  = 6;
    localparam int          FLAG_CLEAR_EN_POS = 7;

    localparam logic [7:0]  ADDR_HIGH_RESET   = 8'hff;
    localparam logic [7:0]  ADDR_LOW_RESET    = 8'hfe;
    localparam logic [7:0]  STATUS_CTRL_RESET = 8'h00;
    localparam logic [7:0]  FLAG_CTRL_RESET   = 8'h00;

    localparam int          SYNC_STAGES       = 2;

    typedef struct packed {
        logic [15:0] addr;
        logic        bus_cycle;
        logic        opcode_fetch;
    } core_bus_t;

    typedef struct packed {
        logic       addr_high_wr;
        logic       addr_low_wr;
        logic       status_ctrl_wr;
        logic       flag_ctrl_wr;
        logic [7:0] wdata;
    } reg_write_t;

    typedef struct packed {
        logic [15:0] vector;
        logic        force_swi;
        logic        in_break;
    } break_entry_t;

    typedef enum logic [1:0] {
        RUN,
        BREAK_HELD
    } break_state_t;

endpackage

// ==== hw/break_sync2.sv ====
// Two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module break_sync2 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [break_pkg::SYNC_STAGES-1:0] stage;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
        end else begin
            stage <= {stage[break_pkg::SYNC_STAGES-2:0], async_in};
        end
    end

    assign sync_out = stage[break_pkg::SYNC_STAGES-1];
endmodule

// ==== hw/break_addr_cmp.sv ====
// Comparator of the internal address bus against the programmed break address
`timescale 1ns/1ps
module break_addr_cmp (
    input  wire logic [7:0]  addr_high,
    input  wire logic [7:0]  addr_low,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_cycle,
    output logic             hit
);
    wire [15:0] compare_value = {addr_high, addr_low};

    // Full 16-bit compare on every valid bus cycle
    assign hit = bus_cycle && (bus_addr == compare_value);
endmodule

// ==== hw/address_break_unit.sv ====
// Address break unit: break detection, entry, and break-state side effects
`timescale 1ns/1ps
module address_break_unit (
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_N,
    input  wire break_pkg::core_bus_t   CORE_BUS,
    input  wire logic                   MONITOR_MODE,
    input  wire logic                   BREAK_EXIT,
    input  wire break_pkg::reg_write_t  REG_WRITE,
    input  wire logic                   FLAG_CLEAR_REQ,
    input  wire logic                   TEST_VOLTAGE_LEVEL,
    output break_pkg::break_entry_t     BREAK_ENTRY,
    output logic [7:0]                  SWI_OPCODE_OUT,
    output logic [7:0]                  BREAK_ADDRESS_HIGH,
    output logic [7:0]                  BREAK_ADDRESS_LOW,
    output logic [7:0]                  BREAK_STATUS_CTRL,
    output logic [7:0]                  BREAK_FLAG_CTRL,
    output logic                        FLAG_CLEAR_GRANT,
    output logic                        TIMER_ONE_HALT,
    output logic                        TIMER_TWO_HALT,
    output logic                        WATCHDOG_DISABLE
);

    // Register file
    logic [7:0] break_address_high_reg;
    logic [7:0] break_address_low_reg;
    logic       break_enable;
    logic       break_request_bit;
    logic       break_flag_clear_enable;

    // Break tracking
    logic                    armed;
    logic                    taken;
    break_pkg::break_state_t state;
    logic                    test_level;

    // Registered outputs
    logic        force_swi;
    logic [15:0] vector;
    logic        flag_clear_grant;
    logic        timer_halt;
    logic        watchdog_disable;

    // Decoded terms
    wire         addr_hit;
    wire         armed_hit;
    wire         sw_set;
    wire         sw_clear;
    wire         request_set;
    wire         opcode_hit;
    wire         pending;
    wire         take_break;
    wire         in_break;
    wire         addr_written;
    wire [15:0]  next_vector;
    wire         next_request;
    wire         next_armed;
    wire         next_taken;
    wire         clear_allowed;
    wire         next_in_break;

    break_sync2 u_test_sync (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .async_in (TEST_VOLTAGE_LEVEL),
        .sync_out (test_level)
    );

    break_addr_cmp u_cmp (
        .addr_high (break_address_high_reg),
        .addr_low  (break_address_low_reg),
        .bus_addr  (CORE_BUS.addr),
        .bus_cycle (CORE_BUS.bus_cycle),
        .hit       (addr_hit)
    );

    // Software writes to the status/control register
    assign sw_set   = REG_WRITE.status_ctrl_wr
                      && REG_WRITE.wdata[break_pkg::CTRL_REQUEST_POS];
    assign sw_clear = REG_WRITE.status_ctrl_wr
                      && !REG_WRITE.wdata[break_pkg::CTRL_REQUEST_POS];

    assign addr_written = REG_WRITE.addr_high_wr || REG_WRITE.addr_low_wr;

    // A match only counts while armed, so a cleared request at the same address stays quiet
    assign armed_hit   = break_enable && armed && addr_hit;
    assign request_set = armed_hit || sw_set;

    // Opcode-location match is taken on the same fetch, before that instruction runs
    assign opcode_hit = armed_hit && CORE_BUS.opcode_fetch;

    // Operand matches and software requests wait for the next opcode fetch
    assign pending = break_request_bit && !taken;

    assign take_break = CORE_BUS.bus_cycle && CORE_BUS.opcode_fetch
                        && (opcode_hit || pending);

    // Set wins over a software clear in the same cycle
    assign next_request = request_set ? 1'b1 :
                          sw_clear    ? 1'b0 : break_request_bit;

    // Taken marks the request as serviced until software drops the bit
    assign next_taken = take_break    ? 1'b1 :
                        !next_request ? 1'b0 : taken;

    // Any armed match disarms, operand matches too, so a kept address never repeats
    assign next_armed = addr_written ? 1'b1 :
                        armed_hit    ? 1'b0 : armed;

    assign next_vector = MONITOR_MODE ? break_pkg::VECTOR_MONITOR
                                      : break_pkg::VECTOR_NORMAL;

    assign in_break = (state == break_pkg::BREAK_HELD);

    // Mirrors the next state, so the halts drop at the same edge as the break state
    assign next_in_break = take_break || (in_break && !BREAK_EXIT);

    // Flag clears pass outside break, or inside it only with clear-enable set
    assign clear_allowed = !in_break || break_flag_clear_enable;

    // Register file writes
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            break_address_high_reg <= break_pkg::ADDR_HIGH_RESET;
        end else if (REG_WRITE.addr_high_wr) begin
            break_address_high_reg <= REG_WRITE.wdata;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            break_address_low_reg <= break_pkg::ADDR_LOW_RESET;
        end else if (REG_WRITE.addr_low_wr) begin
            break_address_low_reg <= REG_WRITE.wdata;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            break_enable <= break_pkg::STATUS_CTRL_RESET[break_pkg::CTRL_ENABLE_POS];
        end else if (REG_WRITE.status_ctrl_wr) begin
            break_enable <= REG_WRITE.wdata[break_pkg::CTRL_ENABLE_POS];
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            break_flag_clear_enable <= break_pkg::FLAG_CTRL_RESET[break_pkg::FLAG_CLEAR_EN_POS];
        end else if (REG_WRITE.flag_ctrl_wr) begin
            break_flag_clear_enable <= REG_WRITE.wdata[break_pkg::FLAG_CLEAR_EN_POS];
        end
    end

    // Request bit, service marker and arming
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            break_request_bit <= break_pkg::STATUS_CTRL_RESET[break_pkg::CTRL_REQUEST_POS];
            taken             <= 1'b0;
            armed             <= 1'b1;
        end else begin
            break_request_bit <= next_request;
            taken             <= next_taken;
            armed             <= next_armed;
        end
    end

    // Break state: entered at the forced fetch, left when the core returns
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= break_pkg::RUN;
        end else begin
            unique case (state)
                break_pkg::RUN: begin
                    if (take_break) begin
                        state <= break_pkg::BREAK_HELD;
                    end
                end
                break_pkg::BREAK_HELD: begin
                    // A new entry in the exit cycle keeps the break held
                    if (BREAK_EXIT && !take_break) begin
                        state <= break_pkg::RUN;
                    end
                end
                default: begin
                    state <= break_pkg::RUN;
                end
            endcase
        end
    end

    // Entry strobe and vector, one cycle after the fetch address
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            force_swi <= 1'b0;
            vector    <= break_pkg::VECTOR_NORMAL;
        end else begin
            force_swi <= take_break;
            if (take_break) begin
                vector <= next_vector;
            end
        end
    end

    // Side effects of the break state
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_clear_grant <= 1'b0;
            timer_halt       <= 1'b0;
            watchdog_disable <= 1'b0;
        end else begin
            flag_clear_grant <= FLAG_CLEAR_REQ && clear_allowed;
            timer_halt       <= next_in_break;
            watchdog_disable <= next_in_break && test_level;
        end
    end

    // Outputs, all from flip-flops except SWI_OPCODE_OUT, which is the constant SWI_OPCODE
    assign BREAK_ENTRY           = '{vector: vector, force_swi: force_swi, in_break: timer_halt};
    assign SWI_OPCODE_OUT        = break_pkg::SWI_OPCODE;
    assign BREAK_ADDRESS_HIGH    = break_address_high_reg;
    assign BREAK_ADDRESS_LOW     = break_address_low_reg;
    assign BREAK_FLAG_CTRL       = {break_flag_clear_enable, 7'h00};
    assign FLAG_CLEAR_GRANT      = flag_clear_grant;
    assign TIMER_ONE_HALT        = timer_halt;
    assign TIMER_TWO_HALT        = timer_halt;
    assign WATCHDOG_DISABLE      = watchdog_disable;

    // Status readback shows enable and live request bit
    assign BREAK_STATUS_CTRL     = {break_enable, break_request_bit, 6'h00};

endmodule

// ==== tb/address_break_unit_assertions.sv ====
// Port checker for the address break unit, bound to the design
`timescale 1ns/1ps
module address_break_unit_assertions (
    input wire logic                    REF_CLK,
    input wire logic                    RST_N,
    input wire break_pkg::core_bus_t    CORE_BUS,
    input wire logic                    MONITOR_MODE,
    input wire logic                    BREAK_EXIT,
    input wire break_pkg::reg_write_t   REG_WRITE,
    input wire logic                    FLAG_CLEAR_REQ,
    input wire logic                    TEST_VOLTAGE_LEVEL,
    input wire break_pkg::break_entry_t BREAK_ENTRY,
    input wire logic [7:0]              BREAK_ADDRESS_HIGH,
    input wire logic [7:0]              BREAK_ADDRESS_LOW,
    input wire logic [7:0]              BREAK_STATUS_CTRL,
    input wire logic [7:0]              BREAK_FLAG_CTRL,
    input wire logic                    FLAG_CLEAR_GRANT,
    input wire logic                    TIMER_ONE_HALT,
    input wire logic                    TIMER_TWO_HALT,
    input wire logic                    WATCHDOG_DISABLE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic armed;
    wire  ib  = BREAK_ENTRY.in_break;
    wire  awr = REG_WRITE.addr_high_wr | REG_WRITE.addr_low_wr;
    wire  hit = CORE_BUS.bus_cycle & BREAK_STATUS_CTRL[7] & armed & !ib & !awr
              & (CORE_BUS.addr == {BREAK_ADDRESS_HIGH, BREAK_ADDRESS_LOW});
    // Only an address write rearms, so a stale address never matches twice
    always_ff @(posedge REF_CLK or negedge RST_N)
        if (!RST_N) armed <= 1'b1;
        else armed <= awr | (armed & !hit);
    property p_hit_fetch; hit && CORE_BUS.opcode_fetch |=> BREAK_ENTRY.force_swi && ib
        && TIMER_ONE_HALT && TIMER_TWO_HALT; endproperty
    a_hit_fetch: assert property (p_hit_fetch) else $error("no break on fetch");
    property p_hit_op; hit && !CORE_BUS.opcode_fetch |=> BREAK_STATUS_CTRL[6]
        && !BREAK_ENTRY.force_swi; endproperty
    a_hit_op: assert property (p_hit_op) else $error("operand match");
    property p_entry; $rose(ib) |-> $past(CORE_BUS.bus_cycle && CORE_BUS.opcode_fetch); endproperty
    a_entry: assert property (p_entry) else $error("entry off fetch");
    property p_vec; BREAK_ENTRY.force_swi |-> BREAK_ENTRY.vector == ($past(MONITOR_MODE)
        ? break_pkg::VECTOR_MONITOR : break_pkg::VECTOR_NORMAL); endproperty
    a_vec: assert property (p_vec) else $error("vector");
    property p_exit; BREAK_EXIT ##1 !BREAK_ENTRY.force_swi |-> !ib && !TIMER_ONE_HALT
        && !TIMER_TWO_HALT && !WATCHDOG_DISABLE; endproperty
    a_exit: assert property (p_exit) else $error("exit");
    property p_grant; FLAG_CLEAR_REQ |=> FLAG_CLEAR_GRANT == $past(!ib || BREAK_FLAG_CTRL[7]);
    endproperty
    a_grant: assert property (p_grant) else $error("grant");
    property p_wdog; TEST_VOLTAGE_LEVEL[*5] ##0 ib |-> WATCHDOG_DISABLE; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog");
    property p_wr; REG_WRITE.addr_high_wr |=> BREAK_ADDRESS_HIGH == $past(REG_WRITE.wdata);
    endproperty
    a_wr: assert property (p_wr) else $error("high write");
endmodule
bind address_break_unit address_break_unit_assertions chk_u (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .CORE_BUS(CORE_BUS), .MONITOR_MODE(MONITOR_MODE),
    .BREAK_EXIT(BREAK_EXIT), .REG_WRITE(REG_WRITE), .FLAG_CLEAR_REQ(FLAG_CLEAR_REQ),
    .TEST_VOLTAGE_LEVEL(TEST_VOLTAGE_LEVEL), .BREAK_ENTRY(BREAK_ENTRY),
    .BREAK_ADDRESS_HIGH(BREAK_ADDRESS_HIGH), .BREAK_ADDRESS_LOW(BREAK_ADDRESS_LOW),
    .BREAK_STATUS_CTRL(BREAK_STATUS_CTRL), .BREAK_FLAG_CTRL(BREAK_FLAG_CTRL),
    .FLAG_CLEAR_GRANT(FLAG_CLEAR_GRANT), .TIMER_ONE_HALT(TIMER_ONE_HALT),
    .TIMER_TWO_HALT(TIMER_TWO_HALT), .WATCHDOG_DISABLE(WATCHDOG_DISABLE));

// ==== tb/core_model.sv ====
// Core model: fetch stream over 48 addresses and a break routine
`timescale 1ns/1ps
module core_model (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire break_pkg::break_entry_t entry,
    input  wire logic                    hold,
    output break_pkg::core_bus_t         bus,
    output logic                         exit_pulse
);
    logic [15:0] pc;
    logic [2:0]  dwell;
    logic        halted;
    wire  [15:0] rel = pc - 16'h8000;
    // Idle bus shows the inverted address so a stale value cannot match
    assign bus = '{addr: halted ? ~pc : pc, bus_cycle: !halted,
                   opcode_fetch: !halted && (rel % 16'd3 == 16'd0)};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= 16'h8000;
            dwell <= '0;
            halted <= 1'b0;
            exit_pulse <= 1'b0;
        end else if (entry.force_swi) begin
            pc <= pc - 16'd1;
            dwell <= 3'd5;
            halted <= 1'b1;
        end else if (halted) begin
            dwell <= (dwell == 3'd0) ? dwell : dwell - 3'd1;
            halted <= (dwell != 3'd0) || hold;
            exit_pulse <= (dwell == 3'd0) && !hold;
        end else begin
            pc <= (rel == 16'd47) ? 16'h8000 : pc + 16'd1;
            exit_pulse <= 1'b0;
        end
    end
endmodule

// ==== tb/address_break_unit_test.sv ====
// Self-checking bench for the address break unit
`timescale 1ns/1ps
module address_break_unit_test;
    logic                    clk = 1'b0;
    logic                    rst_n, mon, tvl, freq, hold, exitp, h1, h2, wd, grant;
    logic [7:0]              opc, ah, al, sc, fc;
    logic [15:0]             last_fetch;
    break_pkg::core_bus_t    bus;
    break_pkg::reg_write_t   wr;
    break_pkg::break_entry_t ent;
    int                      err_count = 0;
    int                      tests_run = 0;
    int                      brk_cnt = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (bus.bus_cycle && bus.opcode_fetch) last_fetch <= bus.addr;
    always @(posedge clk) if (ent.force_swi === 1'b1) brk_cnt++;
    address_break_unit dut_u (
        .REF_CLK(clk), .RST_N(rst_n), .CORE_BUS(bus), .MONITOR_MODE(mon),
        .BREAK_EXIT(exitp), .REG_WRITE(wr), .FLAG_CLEAR_REQ(freq),
        .TEST_VOLTAGE_LEVEL(tvl), .BREAK_ENTRY(ent), .SWI_OPCODE_OUT(opc),
        .BREAK_ADDRESS_HIGH(ah), .BREAK_ADDRESS_LOW(al), .BREAK_STATUS_CTRL(sc),
        .BREAK_FLAG_CTRL(fc), .FLAG_CLEAR_GRANT(grant), .TIMER_ONE_HALT(h1),
        .TIMER_TWO_HALT(h2), .WATCHDOG_DISABLE(wd));
    core_model core_u (.clk(clk), .rst_n(rst_n), .entry(ent), .hold(hold),
        .bus(bus), .exit_pulse(exitp));
    task automatic tally_and_finish;
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wreg(input int sel, input logic [7:0] d);
        @(posedge clk) wr <= {4'h8 >> sel, d};
        @(posedge clk) wr <= '0;
        #1;
    endtask
    task automatic wait_ib(input logic exp, input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            if (ent.in_break === exp) break;
        end
        chk(ent.in_break, exp);
    endtask
    task automatic clear_req(input logic exp);
        @(posedge clk) freq <= 1'b1;
        @(posedge clk) freq <= 1'b0;
        #1 chk(grant, exp);
    endtask
    task automatic do_reset;
        @(posedge clk) rst_n <= 1'b0;
        tick(8);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk({ah, al, sc, fc}, 32'hfffe0000);
        chk(ent, {break_pkg::VECTOR_NORMAL, 2'b00});
        chk(opc, break_pkg::SWI_OPCODE);
    endtask
    initial begin
        logic [7:0] off;
        logic       fce;
        {rst_n, mon, tvl, freq, hold, wr} = '0;
        void'($urandom(32'ha13e));
        do_reset();
        for (int i = 0; i < 12; i++) begin
            off = (i < 2) ? 8'(i) : 8'($urandom_range(47));
            fce = 1'($urandom_range(1));
            @(posedge clk);
            mon <= 1'($urandom_range(1));
            tvl <= 1'($urandom_range(1));
            hold <= 1'b1;
            // Disable first: half-written addresses must not match
            wreg(2, 8'h00);
            wreg(3, {fce, 7'h00});
            chk(fc, {fce, 7'h00});
            wreg(0, 8'h80);
            wreg(1, off);
            wreg(2, 8'h80);
            chk({ah, al}, {8'h80, off});
            wait_ib(1'b1, 200);
            chk(last_fetch, 16'h8000 + 16'((off + 2) / 3 * 3 % 48));
            chk(ent.vector, mon ? 16'hfefc : 16'hfffc);
            chk({h1, h2, wd}, {2'b11, tvl});
            clear_req(fce);
            @(posedge clk) hold <= 1'b0;
            wait_ib(1'b0, 50);
            wreg(2, 8'h80);
            tick(60);
            chk(brk_cnt, i + 1);
            clear_req(1'b1);
        end
        wreg(2, 8'hc0);
        wait_ib(1'b1, 20);
        chk(sc, 8'hc0);
        wait_ib(1'b0, 50);
        // High byte never on the bus, so a low-byte match alone is no break
        wreg(2, 8'h80);
        wreg(0, 8'h00);
        wreg(1, 8'h03);
        tick(60);
        chk(brk_cnt, 13);
        do_reset();
        tally_and_finish();
    end
    // Run needs about 1500 cycles; the limit of 40000 cycles allows some twenty-five times that
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
endmodule
